// ---- verilog/pss_top.sv ----
// serial programming and divider/detector control of the synthesizer
//
// How it works
// - data bit captured into 18-bit shift register on serial clock rise
// - word arrives most significant bit first; first bit ends as bit 17
// - bit 0 selects: 0 feedback register, 1 reference register
// - load strobe rise copies word into the selected register
// - shift register holds 17-bit payload over bits 17..1, select bit 0
// - reference word: test 14, spare 13, polarity 12, float 11, divide 10..1
// - reference divider is 10-bit, divides by 1 to 1023, and by 1024 for a zero divide
// - reference divider output compared with feedback divider output
// - feedback divider: 5-bit swallow plus 10-bit main counter
// - prescaler divides by 32 or 33 under swallow control
// - feedback word: main 17..8, swallow 7..3, control pair 2..1
// - divide by 33 swallow times, by 32 for the rest of main
// - polarity picks pump direction for a lagging feedback
// - polarity 1 positive, 0 negative; float 1 releases the pump outside test mode
// - polarity, float and test bits steer pump direction, pump release and test routing
// - test mode drives pump with reference or feedback divider output
// - outside test mode, pump drives up or down only while phases differ, else floats
// - power gate low powers down at once and floats the pump
// - sleep bit disables dividers and floats pump and detector
// - counter clear resets both dividers, restart aligned
// - serial loading keeps working in every power-down mode
`timescale 1ns/10ps
module pss_top (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic ser_clk_i,
    input wire logic ser_data_i,
    input wire logic load_strobe_i,
    input wire logic power_gate_i,
    input wire logic ref_clock_in_i,
    input wire logic rf_in_i,
    output logic cp_drive_o,
    output logic cp_oe_o,
    output logic powered_down_o
);
    ////////////////////////////////////////////////////////////////////////
    logic [5:0] pin_s;
    logic [5:0] pin_d_r;
    logic ser_rise;
    logic load_rise;
    logic ce_s;
    logic ref_edge;
    logic rf_edge;

    pss_sync #(.W(6)) u_sync (
        .sys_clk_i(sys_clk_i),
        .srst_i(srst_i),
        .d_i({rf_in_i, ref_clock_in_i, power_gate_i, load_strobe_i, ser_data_i, ser_clk_i}),
        .q_o(pin_s)
    );

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            pin_d_r <= '0;
        end else begin
            pin_d_r <= pin_s;
        end
    end

    assign ser_rise = pin_s[0] && !pin_d_r[0];
    assign load_rise = pin_s[2] && !pin_d_r[2];
    assign ce_s = pin_s[3];
    assign ref_edge = pin_s[4] && !pin_d_r[4];
    assign rf_edge = pin_s[5] && !pin_d_r[5];

    ////////////////////////////////////////////////////////////////////////
    logic [pss_pkg::SHIFT_W-1:0] shift_r;
    logic [pss_pkg::REF_W-1:0] ref_cfg_r;
    logic [pss_pkg::FB_W-1:0] fb_cfg_r;

    // shift in, msb first
    // power state is not looked at, so loading goes on while asleep
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            shift_r <= '0;
        end else if (ser_rise) begin
            shift_r <= {shift_r[pss_pkg::SHIFT_W-2:0], pin_s[1]};
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            ref_cfg_r <= pss_pkg::REF_RESET;
            fb_cfg_r <= pss_pkg::FB_RESET;
        end else if (load_rise) begin
            if (shift_r[pss_pkg::SEL_BIT]) begin
                ref_cfg_r <= shift_r[pss_pkg::REF_SH_HI:1];
            end else begin
                fb_cfg_r <= shift_r[pss_pkg::FB_SH_HI:1];
            end
        end
    end

    logic test_mode;
    logic pol;
    logic pump_float;
    logic [pss_pkg::DIV_W-1:0] ref_div;
    logic [pss_pkg::DIV_W-1:0] main_count;
    logic [pss_pkg::SWL_W-1:0] swallow_count;
    logic clear_bit;
    logic sleep_bit;

    assign test_mode = ref_cfg_r[pss_pkg::REF_TEST];
    assign pol = ref_cfg_r[pss_pkg::REF_POL];
    assign pump_float = ref_cfg_r[pss_pkg::REF_FLOAT];
    assign ref_div = ref_cfg_r[pss_pkg::REF_DIV_LO +: pss_pkg::DIV_W];
    assign main_count = fb_cfg_r[pss_pkg::FB_MAIN_LO +: pss_pkg::DIV_W];
    assign swallow_count = fb_cfg_r[pss_pkg::FB_SWL_LO +: pss_pkg::SWL_W];
    assign clear_bit = fb_cfg_r[pss_pkg::FB_CLEAR];
    assign sleep_bit = fb_cfg_r[pss_pkg::FB_SLEEP];

    ////////////////////////////////////////////////////////////////////////
    pss_pkg::pss_pwr_t pwr_r;
    logic ref_f_r;
    logic fb_f_r;
    logic async_down;
    logic cnt_clr;

    assign async_down = !ce_s || (sleep_bit && clear_bit);

    // power sequencing; sync mode waits for pump idle
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            pwr_r <= pss_pkg::PWR_ON;
        end else begin
            case (pwr_r)
                pss_pkg::PWR_ON: begin
                    if (async_down) begin
                        pwr_r <= pss_pkg::PWR_DOWN;
                    end else if (sleep_bit) begin
                        pwr_r <= pss_pkg::PWR_WAIT;
                    end
                end
                pss_pkg::PWR_WAIT: begin
                    if (async_down || (!ref_f_r && !fb_f_r)) begin
                        pwr_r <= pss_pkg::PWR_DOWN;
                    end else if (!sleep_bit) begin
                        pwr_r <= pss_pkg::PWR_ON;
                    end
                end
                pss_pkg::PWR_DOWN: begin
                    if (ce_s && !sleep_bit) begin
                        pwr_r <= pss_pkg::PWR_ON;
                    end
                end
                default: pwr_r <= pss_pkg::PWR_DOWN;
            endcase
        end
    end

    // every divider cleared together, so both restart aligned
    assign cnt_clr = clear_bit || pwr_r == pss_pkg::PWR_DOWN || async_down;

    ////////////////////////////////////////////////////////////////////////
    logic ref_p;
    logic pre_p;
    logic fb_p;
    logic [pss_pkg::SWL_W-1:0] swl_left_r;
    logic [pss_pkg::PRE_W-1:0] modulus;

    pss_div #(.W(pss_pkg::DIV_W)) u_ref_div (
        .sys_clk_i(sys_clk_i),
        .srst_i(srst_i),
        .clr_i(cnt_clr),
        .step_i(ref_edge),
        .limit_i(ref_div),
        .wrap_o(ref_p)
    );

    assign modulus = (swl_left_r != '0) ? pss_pkg::MOD_HIGH : pss_pkg::MOD_LOW;

    pss_div #(.W(pss_pkg::PRE_W)) u_pre (
        .sys_clk_i(sys_clk_i),
        .srst_i(srst_i),
        .clr_i(cnt_clr),
        .step_i(rf_edge),
        .limit_i(modulus),
        .wrap_o(pre_p)
    );

    pss_div #(.W(pss_pkg::DIV_W)) u_main (
        .sys_clk_i(sys_clk_i),
        .srst_i(srst_i),
        .clr_i(cnt_clr),
        .step_i(pre_p),
        .limit_i(main_count),
        .wrap_o(fb_p)
    );

    // swallow count of by-33 cycles, reloaded each feedback period
    always_ff @(posedge sys_clk_i) begin
        if (srst_i || cnt_clr || fb_p) begin
            swl_left_r <= swallow_count;
        end else if (pre_p && swl_left_r != '0) begin
            swl_left_r <= swl_left_r - 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    logic ref_sq_r;
    logic fb_sq_r;

    // divider outputs as square waves for test routing
    always_ff @(posedge sys_clk_i) begin
        if (srst_i || cnt_clr) begin
            ref_sq_r <= 1'b0;
            fb_sq_r <= 1'b0;
        end else begin
            ref_sq_r <= ref_sq_r ^ ref_p;
            fb_sq_r <= fb_sq_r ^ fb_p;
        end
    end

    // phase/frequency detector; coincidence resets both flags
    always_ff @(posedge sys_clk_i) begin
        if (srst_i || cnt_clr) begin
            ref_f_r <= 1'b0;
            fb_f_r <= 1'b0;
        end else if ((ref_p || ref_f_r) && (fb_p || fb_f_r)) begin
            ref_f_r <= 1'b0;
            fb_f_r <= 1'b0;
        end else begin
            ref_f_r <= ref_f_r || ref_p;
            fb_f_r <= fb_f_r || fb_p;
        end
    end

    // pump output; gate pin acts without waiting for the state machine
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            cp_drive_o <= 1'b0;
            cp_oe_o <= 1'b0;
        end else if (!ce_s || pwr_r == pss_pkg::PWR_DOWN) begin
            cp_drive_o <= 1'b0;
            cp_oe_o <= 1'b0;
        end else if (test_mode) begin
            cp_drive_o <= pol ? fb_sq_r : ref_sq_r;
            cp_oe_o <= 1'b1;
        end else if (pump_float) begin
            cp_drive_o <= 1'b0;
            cp_oe_o <= 1'b0;
        end else begin
            cp_drive_o <= ref_f_r ? pol : !pol;
            cp_oe_o <= ref_f_r ^ fb_f_r;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            powered_down_o <= 1'b0;
        end else begin
            powered_down_o <= !ce_s || pwr_r == pss_pkg::PWR_DOWN;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    logic [pss_pkg::DIV_W-1:0] ref_seen_r;

    always_ff @(posedge sys_clk_i) begin
        if (srst_i || cnt_clr || ref_p) begin
            ref_seen_r <= '0;
        end else if (ref_edge) begin
            ref_seen_r <= ref_seen_r + 1'b1;
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);

    property p_shift;
        ser_rise |=> shift_r == {$past(shift_r[pss_pkg::SHIFT_W-2:0]), $past(pin_s[1])};
    endproperty
    a_shift: assert property (p_shift) else $error("shift bit not captured");

    property p_load_ref;
        load_rise && shift_r[0] |=> ref_cfg_r == $past(shift_r[pss_pkg::REF_SH_HI:1]) && $stable(fb_cfg_r);
    endproperty
    a_load_ref: assert property (p_load_ref) else $error("reference word not latched");

    property p_load_fb;
        load_rise && !shift_r[0] |=> fb_cfg_r == $past(shift_r[pss_pkg::FB_SH_HI:1]) && $stable(ref_cfg_r);
    endproperty
    a_load_fb: assert property (p_load_fb) else $error("feedback word not latched");

    property p_hold;
        !load_rise |=> $stable(ref_cfg_r) && $stable(fb_cfg_r);
    endproperty
    a_hold: assert property (p_hold) else $error("register changed without load");

    property p_gate;
        !ce_s |=> !cp_oe_o ##1 !cp_oe_o;
    endproperty
    a_gate: assert property (p_gate) else $error("pump driven with gate low");

    property p_float;
        ce_s && pump_float && !test_mode |=> !cp_oe_o;
    endproperty
    a_float: assert property (p_float) else $error("pump not floated");

    property p_test;
        ce_s && test_mode && pwr_r != pss_pkg::PWR_DOWN |=> cp_oe_o && cp_drive_o == ($past(pol) ? $past(fb_sq_r) : $past(ref_sq_r));
    endproperty
    a_test: assert property (p_test) else $error("test routing wrong");

    property p_pfd;
        ce_s && pwr_r != pss_pkg::PWR_DOWN && !test_mode && !pump_float && ref_f_r && !fb_f_r |=> cp_oe_o && cp_drive_o == $past(pol);
    endproperty
    a_pfd: assert property (p_pfd) else $error("pump direction wrong");

    property p_sync_down;
        pwr_r == pss_pkg::PWR_WAIT && !ref_f_r && !fb_f_r |=> pwr_r == pss_pkg::PWR_DOWN ##1 !cp_oe_o;
    endproperty
    a_sync_down: assert property (p_sync_down) else $error("sync power down missed");

    property p_ref_count;
        ref_p && !cnt_clr && $stable(ref_div) |-> ref_seen_r == ref_div;
    endproperty
    a_ref_count: assert property (p_ref_count) else $error("reference divide wrong");

    c_test: cover property (test_mode && cp_oe_o);
    c_load_ref: cover property (load_rise && shift_r[0]);
    c_sync_down: cover property (pwr_r == pss_pkg::PWR_WAIT ##1 pwr_r == pss_pkg::PWR_DOWN);
    c_pump_up: cover property (cp_oe_o && cp_drive_o);
endmodule

// ---- verilog/pss_pkg.sv ----
// shared constants and types of the synthesizer serial control block
package pss_pkg;
    localparam int SHIFT_W = 18;
    localparam int REF_W = 14;
    localparam int FB_W = 17;
    localparam int DIV_W = 10;
    localparam int SWL_W = 5;
    localparam int PRE_W = 6;
    // shift register layout
    localparam int SEL_BIT = 0;
    localparam int REF_SH_HI = 14;
    localparam int FB_SH_HI = 17;
    // reference register fields
    localparam int REF_TEST = 13;
    localparam int REF_SPARE = 12;
    localparam int REF_POL = 11;
    localparam int REF_FLOAT = 10;
    localparam int REF_DIV_LO = 0;
    // feedback register fields
    localparam int FB_MAIN_LO = 7;
    localparam int FB_SWL_LO = 2;
    localparam int FB_CLEAR = 1;
    localparam int FB_SLEEP = 0;
    // prescaler moduli
    localparam logic [PRE_W-1:0] MOD_LOW = 6'h20;
    localparam logic [PRE_W-1:0] MOD_HIGH = 6'h21;
    // reset values
    localparam logic [REF_W-1:0] REF_RESET = 14'h0002;
    localparam logic [FB_W-1:0] FB_RESET = 17'h0_0180;
    typedef enum logic [1:0] {PWR_ON, PWR_WAIT, PWR_DOWN} pss_pwr_t;
endpackage

// ---- verilog/pss_sync.sv ----
// two-flop synchroniser for a group of outside levels
`timescale 1ns/10ps
module pss_sync #(
    parameter int W = 1
) (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_r;

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            meta_r <= '0;
            q_o <= '0;
        end else begin
            meta_r <= d_i;
            q_o <= meta_r;
        end
    end
endmodule

// ---- verilog/pss_div.sv ----
// programmable divide-by-limit counter with registered wrap pulse
`timescale 1ns/10ps
module pss_div #(
    parameter int W = 10
) (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic clr_i,
    input wire logic step_i,
    input wire logic [W-1:0] limit_i,
    output logic wrap_o
);
    logic [W-1:0] cnt_r;
    logic [W-1:0] last;

    assign last = W'(limit_i - 1'b1);

    always_ff @(posedge sys_clk_i) begin
        if (srst_i || clr_i) begin
            cnt_r <= '0;
            wrap_o <= 1'b0;
        end else if (step_i && cnt_r == last) begin
            cnt_r <= '0;
            wrap_o <= 1'b1;
        end else begin
            cnt_r <= step_i ? W'(cnt_r + 1'b1) : cnt_r;
            wrap_o <= 1'b0;
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);

    property p_div_clear;
        clr_i |=> cnt_r == '0 && !wrap_o;
    endproperty
    a_div_clear: assert property (p_div_clear) else $error("divider not cleared");
endmodule

// ---- bench/pss_host.sv ----
// partner model: host driving the three-wire programming lines
`timescale 1ns/10ps
module pss_host (
    output logic ser_clk_o,
    output logic ser_data_o,
    output logic load_strobe_o
);
    initial begin
        ser_clk_o = 1'b0;
        ser_data_o = 1'b0;
        load_strobe_o = 1'b0;
    end
    ////////////////////////////////////////////////////////////
    // 800 ns serial clock, idle low between frames
    task automatic send(input logic [17:0] word, input bit latch);
        for (int i = 17; i >= 0; i--) begin
            // offsets keep link edges off the system clock's rising edge
            ser_data_o = word[i];
            #325 ser_clk_o = 1'b1;
            #400 ser_clk_o = 1'b0;
            #75;
        end
        // no pull on data: show the inverse once released
        ser_data_o = ~word[0];
        #400 load_strobe_o = latch;
        #400 load_strobe_o = 1'b0;
        #400;
    endtask
endmodule

// ---- bench/tb_pss_top.sv ----
// self-checking bench of the synthesizer serial control block
`timescale 1ns/10ps
module tb_pss_top;
    localparam int K_TOG = 0;
    localparam int K_OE = 1;
    localparam int K_DRV = 2;
    localparam int K_PD = 3;
    typedef struct {int kind; logic [15:0] exp;} pss_note_t;
    logic sys_clk_i, srst_i, power_gate_i, ref_clock_in_i, rf_in_i;
    logic ser_clk, ser_data, load_strobe;
    logic cp_drive_o, cp_oe_o, powered_down_o, prev_drive, prev_oe;
    int fails = 0;
    int comparisons = 0;
    int cycles = 0;
    int toggles = 0;
    int seed = 39;
    logic [9:0] rdiv;
    pss_note_t notes[$];
    event sample_ev;

    pss_top dut_u (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .ser_clk_i(ser_clk), .ser_data_i(ser_data),
        .load_strobe_i(load_strobe), .power_gate_i(power_gate_i), .ref_clock_in_i(ref_clock_in_i),
        .rf_in_i(rf_in_i), .cp_drive_o(cp_drive_o), .cp_oe_o(cp_oe_o), .powered_down_o(powered_down_o));
    pss_host host_u (.ser_clk_o(ser_clk), .ser_data_o(ser_data), .load_strobe_o(load_strobe));

    initial begin
        sys_clk_i = 1'b0;
        forever #50 sys_clk_i = ~sys_clk_i;
    end
    ////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("counts: comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // work runs about 7200 to 7500 cycles
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            $display("CHECK FAILED timeout expected done seen hang");
            end_of_test();
        end
    end

    // toggles of the driven pump level, for the divider squares
    always @(posedge sys_clk_i) begin
        if (prev_oe === 1'b1 && cp_oe_o === 1'b1 && cp_drive_o !== prev_drive) toggles <= toggles + 1;
        prev_drive <= cp_drive_o;
        prev_oe <= cp_oe_o;
    end

    task automatic tally(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_toggles(input logic [15:0] exp);
        tally("toggles", exp, 16'(toggles));
    endtask

    task automatic chk_oe(input logic [15:0] exp);
        tally("cp_oe_o", exp, {15'h0000, cp_oe_o});
    endtask

    task automatic chk_drive(input logic [15:0] exp);
        tally("cp_drive_o", exp, {15'h0000, cp_drive_o});
    endtask

    task automatic chk_pd(input logic [15:0] exp);
        tally("powered_down_o", exp, {15'h0000, powered_down_o});
    endtask

    initial begin
        pss_note_t n;
        forever begin
            @(sample_ev);
            n = notes.pop_front();
            case (n.kind)
                K_TOG: chk_toggles(n.exp);
                K_OE: chk_oe(n.exp);
                K_DRV: chk_drive(n.exp);
                default: chk_pd(n.exp);
            endcase
        end
    end
    ////////////////////////////////////////////////////////////
    task automatic expect_out(input int kind, input logic [15:0] exp);
        @(negedge sys_clk_i);
        notes.push_back('{kind, exp});
        ->sample_ev;
    endtask

    task automatic pulses(input bit on_rf, input int n);
        repeat (n) begin
            @(posedge sys_clk_i);
            #1;
            if (on_rf) rf_in_i = 1'b1;
            else ref_clock_in_i = 1'b1;
            repeat (3) @(posedge sys_clk_i);
            #1;
            rf_in_i = 1'b0;
            ref_clock_in_i = 1'b0;
            repeat (2) @(posedge sys_clk_i);
        end
        repeat (10) @(posedge sys_clk_i);
        #1;
    endtask

    task automatic load(input logic [17:0] word);
        host_u.send(word, 1'b1);
        repeat (6) @(posedge sys_clk_i);
        #1;
    endtask

    task automatic set_gate(input logic level);
        @(posedge sys_clk_i);
        #1 power_gate_i = level;
        repeat (6) @(posedge sys_clk_i);
        #1;
    endtask

    // spare zero, ignored top bits random
    function automatic logic [17:0] rword(input logic test, input logic pol, input logic flt);
        return {3'($random(seed)), test, 1'b0, pol, flt, rdiv, 1'b1};
    endfunction

    // main 3, swallow 1: divide by 97
    function automatic logic [17:0] nword(input logic clr, input logic slp);
        return {10'h003, 5'h01, clr, slp, 1'b0};
    endfunction

    task automatic restart();
        load(nword(1'b1, 1'b0));
        expect_out(K_PD, 16'h0000);
        load(nword(1'b0, 1'b0));
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        srst_i = 1'b1;
        power_gate_i = 1'b1;
        ref_clock_in_i = 1'b0;
        rf_in_i = 1'b0;
        rdiv = 10'(2 + ($random(seed) & 7));
        repeat (6) @(posedge sys_clk_i);
        #1 srst_i = 1'b0;
        repeat (6) @(posedge sys_clk_i);
        expect_out(K_PD, 16'h0000);
        expect_out(K_OE, 16'h0000);
        $display("test reset done");
        load(rword(1'b1, 1'b0, 1'b1));
        restart();
        toggles = 0;
        pulses(1'b0, 3 * rdiv);
        expect_out(K_TOG, 16'h0003);
        expect_out(K_OE, 16'h0001);
        $display("test reference square done");
        set_gate(1'b0);
        expect_out(K_PD, 16'h0001);
        expect_out(K_OE, 16'h0000);
        load(rword(1'b1, 1'b1, 1'b1));
        set_gate(1'b1);
        expect_out(K_PD, 16'h0000);
        toggles = 0;
        // one edge short of two periods: a divide of 96 would show two here
        pulses(1'b1, 193);
        expect_out(K_TOG, 16'h0001);
        pulses(1'b1, 1);
        expect_out(K_TOG, 16'h0002);
        $display("test feedback square done");
        host_u.send(rword(1'b0, 1'b1, 1'b0), 1'b0);
        toggles = 0;
        pulses(1'b1, 97);
        expect_out(K_TOG, 16'h0001);
        $display("test no strobe done");
        load(rword(1'b0, 1'b1, 1'b0));
        restart();
        pulses(1'b1, 97);
        expect_out(K_OE, 16'h0001);
        expect_out(K_DRV, 16'h0000);
        pulses(1'b0, rdiv);
        expect_out(K_OE, 16'h0000);
        pulses(1'b0, rdiv);
        expect_out(K_DRV, 16'h0001);
        pulses(1'b1, 97);
        load(rword(1'b0, 1'b0, 1'b0));
        pulses(1'b0, rdiv);
        expect_out(K_OE, 16'h0001);
        expect_out(K_DRV, 16'h0000);
        pulses(1'b1, 97);
        expect_out(K_OE, 16'h0000);
        load(rword(1'b0, 1'b0, 1'b1));
        pulses(1'b0, rdiv);
        expect_out(K_OE, 16'h0000);
        pulses(1'b1, 97);
        $display("test pump done");
        // sync power down waits for the pending pump event
        pulses(1'b0, rdiv);
        load(nword(1'b0, 1'b1));
        expect_out(K_PD, 16'h0000);
        pulses(1'b1, 97);
        expect_out(K_PD, 16'h0001);
        load(nword(1'b1, 1'b1));
        expect_out(K_PD, 16'h0001);
        expect_out(K_OE, 16'h0000);
        load(nword(1'b0, 1'b1));
        expect_out(K_PD, 16'h0001);
        load(nword(1'b0, 1'b0));
        expect_out(K_PD, 16'h0000);
        $display("test sleep done");
        repeat (3) @(posedge sys_clk_i);
        end_of_test();
    end
endmodule
